/* File: rtl/dcf_consts.svh */
// constants for the dual-clock flagged fifo
`ifndef DCF_CONSTS_SVH
`define DCF_CONSTS_SVH

// ----------------------------------------
// storage geometry
// ----------------------------------------
`define DCF_DATA_W 18
`define DCF_DEPTH 64
`define DCF_PTR_W 7
`define DCF_IDX_W 6
`define DCF_OFF_W 5
`define DCF_DEPTH_CNT 7'h40
`define DCF_HALF_CNT 7'h20
`define DCF_OFF_DEFAULT 5'h08

// ----------------------------------------
// register bus
// ----------------------------------------
`define DCF_ADDR_W 8
`define DCF_REG_CTRL 8'h00
`define DCF_REG_STATUS 8'h04
`define DCF_REG_OFFSETS 8'h08
`define DCF_CTRL_INHIBIT_BIT 0
`define DCF_STAT_FULL_BIT 8
`define DCF_STAT_EMPTY_BIT 9
`define DCF_STAT_HALF_BIT 10
`define DCF_STAT_AFE_BIT 11
`define DCF_STAT_PROG_BIT 12
`define DCF_OFF_Y_LSB 8
`define DCF_CTRL_RESET 1'h0
`define DCF_RESP_OKAY 2'h0
`define DCF_RESP_SLVERR 2'h2

`endif

/* File: rtl/dcf_pkg.sv */
// types for the dual-clock flagged fifo
`include "dcf_consts.svh"

package dcf_pkg;

    typedef struct packed {
        logic [`DCF_DEPTH-1:0][`DCF_DATA_W-1:0] mem;
        logic [`DCF_DATA_W-1:0] dout;
        logic [`DCF_PTR_W-1:0] wr_ptr;
        logic [`DCF_PTR_W-1:0] rd_ptr;
        logic ld_prev;
        logic un_prev;
        logic prog_open;
        logic prog_second;
        logic [`DCF_OFF_W-1:0] off_x;
        logic [`DCF_OFF_W-1:0] off_y;
        logic inhibit;
        logic aw_hold;
        logic [`DCF_ADDR_W-1:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dcf_state_t;

endpackage

/* File: rtl/dcf_fifo.sv */
// dual-clock 64x18 fifo with full, empty, half-full and programmable flag
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
`include "dcf_consts.svh"

// What this block does
// - Stores up to 64 words of 18 bits in first-in first-out order.
// - Load clock rising edge writes data_in unless buffer is full or the CTRL inhibit bit is set.
// - Unload clock rising edge advances to next word unless buffer is empty.
// - Full flag low when loaded exceeds unloaded by 64, else high.
// - Empty flag low while nothing stored, high otherwise.
// - Half-full flag high at 32 or more words, low at 31 or fewer.
// - Programmable flag high when count at most X or at least 64 minus Y.
// - With program enable held high, both offsets default to 8.
// - First programming load edge after reset stores data_in[4:0] into X and Y.
// - A second programming load edge overwrites only Y.
// - Programming load edges before the first stored word never write into the buffer memory.
// - Offsets are five-bit values from 0 to 31.
// - Reset clears pointers, full flag high, half-full and empty flags low.
// - Programmable flag reads high after reset.
// - Reset leaves the output word undefined.
// - First word into empty buffer appears on data_out without unloading.
// - Output is non-inverted and released while output enable is high.
// - Works for asynchronous or identical load and unload clocks.
module dcf_fifo
    import dcf_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [`DCF_ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [`DCF_ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic load_clock, // producer load strobe, sampled on aclk
    input wire logic unload_clock, // consumer unload strobe, sampled on aclk
    input wire logic [`DCF_DATA_W-1:0] data_in, // word to load or offset value
    input wire logic program_enable_n, // offset programming enable, active low
    input wire logic output_enable_n, // data output enable, active low
    output logic [`DCF_DATA_W-1:0] data_out, // head word
    output logic data_out_oe_n, // low while data_out is driven
    output logic full_n, // low when full
    output logic empty_n, // low when empty
    output logic half_full_flag, // high at 32 or more words
    output logic almost_full_empty_flag // high near empty or near full
);

    dcf_state_t st_ff;
    dcf_state_t nxt_st;

    logic [`DCF_PTR_W-1:0] count;
    logic is_full;
    logic is_empty;
    logic ld_rise;
    logic un_rise;
    logic prog_hit;
    logic do_wr;
    logic do_rd;
    logic aw_take;
    logic w_take;
    logic aw_have;
    logic w_have;
    logic [`DCF_ADDR_W-1:0] wr_addr;
    logic [3:0] wr_strb;
    logic [31:0] wr_data;
    logic [`DCF_PTR_W-1:0] low_lim;
    logic [`DCF_PTR_W-1:0] high_lim;
    logic [`DCF_DEPTH-1:0] ent_wr;

    // ----------------------------------------
    // level and flag decode
    // ----------------------------------------
    // both strobes sampled on aclk, pointers never cross a clock boundary
    assign count = st_ff.wr_ptr - st_ff.rd_ptr;
    assign is_full = (count == `DCF_DEPTH_CNT);
    assign is_empty = (count == 7'h00);
    assign low_lim = {2'h0, st_ff.off_x};
    assign high_lim = `DCF_DEPTH_CNT - {2'h0, st_ff.off_y};

    assign full_n = ~is_full | ~aresetn;
    assign empty_n = ~is_empty & aresetn;
    assign half_full_flag = (count >= `DCF_HALF_CNT) & aresetn;
    // after reset the count is zero, so the flag shows high
    assign almost_full_empty_flag = (count <= low_lim) | (count >= high_lim)
        | ~aresetn;

    assign data_out = st_ff.dout;
    assign data_out_oe_n = output_enable_n;

    assign s_axi_awready = ~st_ff.aw_hold & ~st_ff.bvalid;
    assign s_axi_wready = ~st_ff.w_hold & ~st_ff.bvalid;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = ~st_ff.rvalid;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;

    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign aw_have = st_ff.aw_hold | aw_take;
    assign w_have = st_ff.w_hold | w_take;
    assign wr_addr = st_ff.aw_hold ? st_ff.aw_addr : s_axi_awaddr;
    assign wr_data = st_ff.w_hold ? st_ff.w_data : s_axi_wdata;
    assign wr_strb = st_ff.w_hold ? st_ff.w_strb : s_axi_wstrb;

    assign ld_rise = load_clock & ~st_ff.ld_prev;
    assign un_rise = unload_clock & ~st_ff.un_prev;
    assign prog_hit = ld_rise & st_ff.prog_open & ~program_enable_n;
    assign do_wr = ld_rise & ~prog_hit & ~is_full & ~st_ff.inhibit;
    assign do_rd = un_rise & ~is_empty;

    // ----------------------------------------
    // per-entry write select
    // ----------------------------------------
    for (genvar e = 0; e < `DCF_DEPTH; e++) begin : g_ent
        localparam logic [`DCF_IDX_W-1:0] ENT_IDX = e;
        assign ent_wr[e] = do_wr & (st_ff.wr_ptr[`DCF_IDX_W-1:0] == ENT_IDX);
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ld_prev = load_clock;
        nxt_st.un_prev = unload_clock;

        // offset programming window, open until the first stored word
        if (prog_hit) begin
            if (!st_ff.prog_second) begin
                nxt_st.off_x = data_in[`DCF_OFF_W-1:0];
                nxt_st.off_y = data_in[`DCF_OFF_W-1:0];
                nxt_st.prog_second = 1'h1;
            end else begin
                nxt_st.off_y = data_in[`DCF_OFF_W-1:0];
            end
        end

        for (int e = 0; e < `DCF_DEPTH; e++) begin
            if (ent_wr[e]) begin
                nxt_st.mem[e] = data_in;
            end
        end
        if (do_wr) begin
            nxt_st.wr_ptr = st_ff.wr_ptr + 7'h01;
            nxt_st.prog_open = 1'h0;
        end
        if (do_rd) begin
            nxt_st.rd_ptr = st_ff.rd_ptr + 7'h01;
        end
        // head word follows the read pointer, so a first load shows at once
        nxt_st.dout = nxt_st.mem[nxt_st.rd_ptr[`DCF_IDX_W-1:0]];

        // register write channel
        if (aw_take) begin
            nxt_st.aw_hold = 1'h1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (w_take) begin
            nxt_st.w_hold = 1'h1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'h0;
        end
        if (aw_have && w_have && !st_ff.bvalid) begin
            nxt_st.aw_hold = 1'h0;
            nxt_st.w_hold = 1'h0;
            nxt_st.bvalid = 1'h1;
            nxt_st.bresp = `DCF_RESP_OKAY;
            unique case (wr_addr)
                `DCF_REG_CTRL: begin
                    if (wr_strb[0]) begin
                        nxt_st.inhibit = wr_data[`DCF_CTRL_INHIBIT_BIT];
                    end
                end
                `DCF_REG_STATUS, `DCF_REG_OFFSETS: begin
                end
                default: begin
                    nxt_st.bresp = `DCF_RESP_SLVERR;
                end
            endcase
        end

        // register read channel
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'h0;
        end
        if (s_axi_arvalid && !st_ff.rvalid) begin
            nxt_st.rvalid = 1'h1;
            nxt_st.rresp = `DCF_RESP_OKAY;
            nxt_st.rdata = 32'h0000_0000;
            unique case (s_axi_araddr)
                `DCF_REG_CTRL: begin
                    nxt_st.rdata[`DCF_CTRL_INHIBIT_BIT] = st_ff.inhibit;
                end
                `DCF_REG_STATUS: begin
                    nxt_st.rdata[`DCF_PTR_W-1:0] = count;
                    nxt_st.rdata[`DCF_STAT_FULL_BIT] = full_n;
                    nxt_st.rdata[`DCF_STAT_EMPTY_BIT] = empty_n;
                    nxt_st.rdata[`DCF_STAT_HALF_BIT] = half_full_flag;
                    nxt_st.rdata[`DCF_STAT_AFE_BIT] = almost_full_empty_flag;
                    nxt_st.rdata[`DCF_STAT_PROG_BIT] = st_ff.prog_open;
                end
                `DCF_REG_OFFSETS: begin
                    nxt_st.rdata[`DCF_OFF_W-1:0] = st_ff.off_x;
                    nxt_st.rdata[`DCF_OFF_Y_LSB +: `DCF_OFF_W] = st_ff.off_y;
                end
                default: begin
                    nxt_st.rresp = `DCF_RESP_SLVERR;
                end
            endcase
        end

        // memory and output word are left as they are
        if (!aresetn) begin
            nxt_st.wr_ptr = 7'h00;
            nxt_st.rd_ptr = 7'h00;
            nxt_st.ld_prev = 1'h1;
            nxt_st.un_prev = 1'h1;
            nxt_st.prog_open = 1'h1;
            nxt_st.prog_second = 1'h0;
            nxt_st.off_x = `DCF_OFF_DEFAULT;
            nxt_st.off_y = `DCF_OFF_DEFAULT;
            nxt_st.inhibit = `DCF_CTRL_RESET;
            nxt_st.aw_hold = 1'h0;
            nxt_st.aw_addr = 8'h00;
            nxt_st.w_hold = 1'h0;
            nxt_st.w_data = 32'h0000_0000;
            nxt_st.w_strb = 4'h0;
            nxt_st.bvalid = 1'h0;
            nxt_st.bresp = `DCF_RESP_OKAY;
            nxt_st.rvalid = 1'h0;
            nxt_st.rdata = 32'h0000_0000;
            nxt_st.rresp = `DCF_RESP_OKAY;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        st_ff <= nxt_st;
    end

endmodule

/* File: verif/dcf_props.sv */
// assertions on the fifo's data and flag ports
`timescale 1ns/100ps
module dcf_props (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset
    input wire logic load_clock, // load strobe
    input wire logic unload_clock, // unload strobe
    input wire logic [17:0] data_in, // load word
    input wire logic program_enable_n, // program enable
    input wire logic output_enable_n, // output enable
    input wire logic [17:0] data_out, // head word
    input wire logic data_out_oe_n, // output driven
    input wire logic full_n, // full
    input wire logic empty_n, // empty
    input wire logic half_full_flag, // half
    input wire logic almost_full_empty_flag // near edge
);
    logic ld_q_ff;
    logic un_q_ff;
    logic win_ff;
    always_ff @(posedge aclk) begin
        ld_q_ff <= aresetn ? load_clock : 1'h1;
        un_q_ff <= aresetn ? unload_clock : 1'h1;
        win_ff <= aresetn ? win_ff & ~empty_n : 1'h1;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_load_empty;
        !empty_n && program_enable_n && load_clock && !ld_q_ff;
    endsequence
    sequence s_prog;
        win_ff && !program_enable_n && load_clock && !ld_q_ff;
    endsequence
    a_reset_flags: assert property ($rose(aresetn) |-> full_n && !empty_n
        && !half_full_flag && almost_full_empty_flag) else $error("flags wrong after reset");
    a_oe_follow: assert property (data_out_oe_n == output_enable_n)
        else $error("output enable not followed");
    a_first_word: assert property (s_load_empty |=> empty_n && data_out == $past(data_in))
        else $error("first word not shown");
    a_full_hold: assert property (!full_n && !(unload_clock && !un_q_ff) |=> !full_n)
        else $error("full left without unload");
    a_empty_hold: assert property (!empty_n && !(load_clock && !ld_q_ff) |=> !empty_n)
        else $error("empty left without load");
    a_full_flags: assert property (!full_n |-> empty_n && half_full_flag
        && almost_full_empty_flag) else $error("flags disagree when full");
    a_empty_afe: assert property (!empty_n |-> almost_full_empty_flag && !half_full_flag)
        else $error("flags disagree when empty");
    a_head_stable: assert property (empty_n && $past(empty_n)
        && !($past(unload_clock) && !$past(un_q_ff)) |-> $stable(data_out))
        else $error("head word moved without unload");
    a_prog_skip: assert property (s_prog |=> !empty_n)
        else $error("programming edge stored a word");
endmodule
bind dcf_fifo dcf_props chk_u (.aclk, .aresetn, .load_clock, .unload_clock, .data_in,
    .program_enable_n, .output_enable_n, .data_out, .data_out_oe_n, .full_n, .empty_n,
    .half_full_flag, .almost_full_empty_flag);

/* File: verif/dcf_partner.sv */
// producer and consumer model at the fifo's far side
`timescale 1ns/100ps
module dcf_partner (
    input wire logic aclk, // clock
    output logic load_clock, // load strobe
    output logic unload_clock, // unload strobe
    output logic [17:0] data_in, // load word
    output logic program_enable_n // program enable
);
    initial begin
        load_clock = 1'h0;
        unload_clock = 1'h0;
        data_in = 18'h0;
        program_enable_n = 1'h1;
    end
    // called only while the load strobe is low
    task automatic set_pen(input logic v);
        @(posedge aclk);
        program_enable_n <= v;
    endtask
    task automatic push(input logic [17:0] w, input int slow);
        @(posedge aclk);
        load_clock <= 1'h1;
        data_in <= w;
        @(posedge aclk);
        load_clock <= 1'h0;
        data_in <= ~w;
        repeat (slow) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic pop(input int slow);
        @(posedge aclk);
        unload_clock <= 1'h1;
        @(posedge aclk);
        unload_clock <= 1'h0;
        repeat (slow) @(posedge aclk);
        @(negedge aclk);
    endtask
endmodule

/* File: verif/dcf_fifo_bench.sv */
// self-checking bench for the dual-clock flagged fifo
`timescale 1ns/100ps
`include "dcf_consts.svh"
module dcf_fifo_bench;
    logic aclk;
    logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic load_clock, unload_clock, program_enable_n, output_enable_n, data_out_oe_n;
    logic full_n, empty_n, half_full_flag, almost_full_empty_flag;
    logic [17:0] data_in, data_out;
    int n_fail = 0;
    int samples_checked = 0;
    int ox = 8;
    int oy = 8;
    dcf_fifo dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .load_clock, .unload_clock, .data_in,
        .program_enable_n, .output_enable_n, .data_out, .data_out_oe_n, .full_n, .empty_n,
        .half_full_flag, .almost_full_empty_flag);
    dcf_partner far_u (.aclk, .load_clock, .unload_clock, .data_in, .program_enable_n);
    initial begin
        aclk = 1'h0;
        forever #10 aclk = ~aclk;
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk("bresp", 32'(s_axi_bresp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        s_axi_rready <= 1'h0;
        chk("rresp", 32'(s_axi_rresp), 32'(er));
    endtask
    function automatic logic [31:0] flg(input int n);
        return 32'({n < 64, n > 0, n >= 32, n <= ox || n >= 64 - oy});
    endfunction
    function automatic logic [17:0] wd(input int i);
        return 18'(i * 32'h0000_2F1D) ^ 18'h2A5A5;
    endfunction
    task automatic chk_flags(input int n);
        chk("flags", 32'({full_n, empty_n, half_full_flag, almost_full_empty_flag}), flg(n));
    endtask
    task automatic t_reset;
        chk("flags", 32'({full_n, empty_n, half_full_flag, almost_full_empty_flag}), 32'h9);
        rd(`DCF_REG_OFFSETS, `DCF_RESP_OKAY);
        chk("offsets", d, 32'h0000_0808);
        rd(8'h10, `DCF_RESP_SLVERR);
        chk("unmapped", d, 32'h0);
        wr(8'h0C, 32'h1, `DCF_RESP_SLVERR);
        $display("reset test done");
    endtask
    task automatic t_program;
        far_u.set_pen(1'h0);
        far_u.push(18'h3FFFF, 0);
        far_u.push(18'h20004, 1);
        far_u.set_pen(1'h1);
        rd(`DCF_REG_OFFSETS, `DCF_RESP_OKAY);
        chk("offsets", d, 32'h0000_041F);
        ox = 31;
        oy = 4;
        chk("empty", 32'(empty_n), 32'h0);
        $display("program test done");
    endtask
    task automatic t_fill;
        for (int i = 0; i < 64; i++) begin
            far_u.push(wd(i), i % 3);
            chk_flags(i + 1);
        end
        chk("head", 32'(data_out), 32'(wd(0)));
        far_u.push(wd(64), 0);
        rd(`DCF_REG_STATUS, `DCF_RESP_OKAY);
        chk("count", 32'(d[6:0]), 32'd64);
        $display("fill test done");
    endtask
    task automatic t_drain;
        far_u.pop(0);
        wr(`DCF_REG_CTRL, 32'h1, `DCF_RESP_OKAY);
        far_u.push(wd(99), 0);
        rd(`DCF_REG_STATUS, `DCF_RESP_OKAY);
        chk("count", 32'(d[6:0]), 32'd63);
        wr(`DCF_REG_CTRL, 32'h0, `DCF_RESP_OKAY);
        for (int i = 1; i < 64; i++) begin
            chk("head", 32'(data_out), 32'(wd(i)));
            far_u.pop(i % 2);
            chk_flags(63 - i);
        end
        far_u.pop(0);
        rd(`DCF_REG_STATUS, `DCF_RESP_OKAY);
        chk("count", 32'(d[6:0]), 32'd0);
        far_u.push(wd(7), 0);
        chk("head", 32'(data_out), 32'(wd(7)));
        $display("drain test done");
    endtask
    task automatic t_oe;
        @(posedge aclk);
        output_enable_n <= 1'h1;
        @(negedge aclk);
        chk("oe", 32'(data_out_oe_n), 32'h1);
        @(posedge aclk);
        output_enable_n <= 1'h0;
        @(negedge aclk);
        chk("oe", 32'(data_out_oe_n), 32'h0);
        $display("output enable test done");
    endtask
    task automatic t_rerun;
        for (int i = 0; i < 63; i++) begin
            far_u.push(wd(i), 0);
        end
        chk("flags", 32'({full_n, empty_n, half_full_flag, almost_full_empty_flag}), 32'h7);
        @(posedge aclk);
        aresetn <= 1'h0;
        @(negedge aclk);
        chk("flags", 32'({full_n, empty_n, half_full_flag, almost_full_empty_flag}), 32'h9);
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        rd(`DCF_REG_STATUS, `DCF_RESP_OKAY);
        chk("count", 32'(d[6:0]), 32'd0);
        rd(`DCF_REG_OFFSETS, `DCF_RESP_OKAY);
        chk("offsets", d, 32'h0000_0808);
        ox = 8;
        oy = 8;
        for (int i = 0; i < 57; i++) begin
            far_u.push(wd(i + 5), 0);
            chk_flags(i + 1);
        end
        chk("head", 32'(data_out), 32'(wd(5)));
        $display("mid-run reset test done");
    endtask
    initial begin
        aresetn = 1'h0;
        output_enable_n = 1'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_awaddr = 8'h0;
        s_axi_araddr = 8'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        t_reset;
        t_program;
        t_fill;
        t_drain;
        t_oe;
        t_rerun;
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        complete_run;
    end
endmodule
